// File: verilog/psr_ctrl.sv
// Purpose: Peripheral soft reset controller: timed active-low resets of seven peripheral groups.
// Assumes: Registers are reached over AXI4-Lite; all logic runs on aclk.
// Notes:   Reserved control bits are dropped on write and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"

module psr_ctrl
  import psr_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PSR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PSR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        audio_uart_spi_rst_n,
  output logic                        card_audio_rst_n,
  output logic                        dma_rst_n,
  output logic                        usb_rst_n,
  output logic                        analog_rst_n,
  output logic                        timer_rst_n,
  output logic                        i2c_rst_n,
  output logic                        reset_busy
);

  // ****************************************************************
  // Bus slave and register decode
  // ****************************************************************

  psr_wr_type         wr;
  logic               wr_ok;
  logic               rd_take;
  logic [31:0]        rd_data;
  logic               rd_ok;
  logic               wr_count_hit;
  logic               wr_ctrl_hit;
  logic [7:0]         set_bits;
  psr_ctrl_state_type r_reg;
  psr_ctrl_state_type r_next;

  psr_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_ok         (wr_ok),
    .rd_take       (rd_take),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Word decode; the two low address bits are ignored.
  assign wr_count_hit = wr.en && ({wr.addr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_COUNT_ADDR);
  assign wr_ctrl_hit  = wr.en && ({wr.addr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_CTRL_ADDR);
  assign wr_ok        = wr_count_hit || wr_ctrl_hit;

  // Only ones in implemented positions start a reset; zeros and reserved bits are dropped.
  assign set_bits = (wr_ctrl_hit && wr.strb[0]) ? (wr.data[7:0] & `PSR_CTRL_MASK) : 8'h00;

  // Read mux: the control word shows the live held-in-reset state.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if ({s_axi_araddr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_CTRL_ADDR) begin
      rd_data = {24'h00_0000, r_reg.held};
    end else if ({s_axi_araddr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_COUNT_ADDR) begin
      rd_data = {16'h0000, r_reg.count};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Countdown and held bits
  // ****************************************************************

  // Next state: count register writes, reset starts and the shared countdown.
  always_comb begin
    r_next = r_reg;
    if (wr_count_hit && wr.strb[0]) begin
      r_next.count[7:0] = wr.data[7:0];
    end
    if (wr_count_hit && wr.strb[1]) begin
      r_next.count[15:8] = wr.data[15:8];
    end
    case (r_reg.phase)
      PSR_IDLE: begin
        if (set_bits != 8'h00) begin
          r_next.held      = set_bits;
          r_next.remaining = r_reg.count;
          r_next.phase     = PSR_HOLD;
        end
      end
      PSR_HOLD: begin
        if (set_bits != 8'h00) begin
          r_next.held      = r_reg.held | set_bits;
          r_next.remaining = r_reg.count;
        end else if (r_reg.remaining <= 16'h0001) begin
          r_next.held      = `PSR_CTRL_RESET;
          r_next.remaining = 16'h0000;
          r_next.phase     = PSR_IDLE;
        end else begin
          r_next.remaining = r_reg.remaining - 16'h0001;
        end
      end
      default: begin
        r_next.phase     = PSR_IDLE;
        r_next.held      = `PSR_CTRL_RESET;
        r_next.remaining = 16'h0000;
      end
    endcase
  end

  // State register; chip reset clears every held bit and the countdown.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg.phase     <= PSR_IDLE;
      r_reg.count     <= `PSR_COUNT_RESET;
      r_reg.held      <= `PSR_CTRL_RESET;
      r_reg.remaining <= 16'h0000;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Group reset outputs
  // ****************************************************************

  // Each held bit drives its group reset low.
  assign audio_uart_spi_rst_n = !r_reg.held[`PSR_GROUP_FOUR_RESET_BIT];
  assign card_audio_rst_n     = !r_reg.held[`PSR_GROUP_THREE_RESET_BIT];
  assign dma_rst_n            = !r_reg.held[`PSR_DMA_RESET_BIT];
  assign usb_rst_n            = !r_reg.held[`PSR_USB_RESET_BIT];
  assign analog_rst_n         = !r_reg.held[`PSR_ANALOG_CONVERTER_RESET_BIT];
  assign timer_rst_n          = !r_reg.held[`PSR_TIMER_GROUP_RESET_BIT];
  assign i2c_rst_n            = !r_reg.held[`PSR_I2C_RESET_BIT];
  assign reset_busy           = (r_reg.phase == PSR_HOLD);

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [7:0]  rst_vec;
  logic [15:0] hold_len;
  logic [15:0] want_len;
  logic        load_now;

  // Output pins gathered in control bit order.
  assign rst_vec  = {audio_uart_spi_rst_n, 1'b1, card_audio_rst_n, dma_rst_n,
                     usb_rst_n, analog_rst_n, timer_rst_n, i2c_rst_n};
  assign load_now = (set_bits != 8'h00);

  // Length of the current hold and the length it must reach.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_len <= 16'h0000;
      want_len <= 16'h0001;
    end else if (load_now) begin
      hold_len <= 16'h0001;
      want_len <= (r_reg.count == 16'h0000) ? 16'h0001 : r_reg.count;
    end else if (r_reg.phase == PSR_HOLD) begin
      hold_len <= hold_len + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking

  a_set_starts: assert property (disable iff (!aresetn)
    load_now |=> ((r_reg.held & $past(set_bits)) == $past(set_bits)) && reset_busy)
    else $error("Written one did not start a reset.");

  a_zero_keeps: assert property (disable iff (!aresetn)
    (reset_busy && r_reg.remaining > 16'h0001) |=> (r_reg.held & $past(r_reg.held)) == $past(r_reg.held))
    else $error("Held bit dropped before the countdown ended.");

  a_read_held: assert property (disable iff (!aresetn)
    (rd_take && {s_axi_araddr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_CTRL_ADDR)
      |=> s_axi_rvalid && s_axi_rdata[7:0] == ~$past(rst_vec))
    else $error("Control read does not match the reset pins.");

  a_read_upper: assert property (disable iff (!aresetn)
    (rd_take && {s_axi_araddr[`PSR_ADDR_W-1:2], 2'b00} == `PSR_CTRL_ADDR && !reset_busy)
      |=> s_axi_rdata == 32'h0000_0000)
    else $error("Control read is not zero while idle.");

  a_pins_map: assert property (disable iff (!aresetn)
    ~rst_vec == r_reg.held)
    else $error("Reset pins do not follow the held bits.");

  a_hold_length: assert property (disable iff (!aresetn)
    (reset_busy && r_next.phase == PSR_IDLE) |-> hold_len == want_len)
    else $error("Reset held for the wrong number of cycles.");

  a_release_all: assert property (disable iff (!aresetn)
    (reset_busy && r_reg.remaining <= 16'h0001 && !load_now) |=> !reset_busy && rst_vec == 8'hff)
    else $error("Resets not released when the countdown ended.");

  a_shared_drop: assert property (disable iff (!aresetn)
    (r_reg.held != $past(r_reg.held)) |-> (r_reg.held == 8'h00 || (r_reg.held & $past(r_reg.held)) == $past(r_reg.held)))
    else $error("Held bits released one by one.");

  a_chip_reset: assert property (@(posedge aclk)
    !aresetn |=> r_reg.held == 8'h00 && !reset_busy && s_axi_rvalid == 1'b0)
    else $error("Chip reset left a reset running.");

  a_reserved_drop: assert property (disable iff (!aresetn)
    1'b1 |-> (r_reg.held & ~`PSR_CTRL_MASK) == 8'h00)
    else $error("Reserved control bit became set.");

  c_start: cover property (disable iff (!aresetn) $rose(reset_busy));
  c_multi: cover property (disable iff (!aresetn) load_now && set_bits != (set_bits & -set_bits));
  c_retrigger: cover property (disable iff (!aresetn) reset_busy && load_now);
  c_poll_busy: cover property (disable iff (!aresetn) rd_take && reset_busy && r_reg.count >= `PSR_COUNT_MIN);

endmodule

`default_nettype wire

// File: shared/psr_map.svh
// Purpose: Offsets, field positions, reset values and counts of the peripheral soft reset controller.
// Assumes: Included by the package and the design modules by its bare name.
// Notes:   Register byte address is four times the register index.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// ****************************************************************
// Bus geometry and register map
// ****************************************************************
`define PSR_ADDR_W                     16
`define PSR_COUNT_IDX                  16'h1c04
`define PSR_CTRL_IDX                   16'h1c05
`define PSR_COUNT_ADDR                 16'(`PSR_COUNT_IDX * 16'h0004)
`define PSR_CTRL_ADDR                  16'(`PSR_CTRL_IDX * 16'h0004)

// ****************************************************************
// Control register fields
// ****************************************************************
`define PSR_GROUP_FOUR_RESET_BIT       7
`define PSR_GROUP_THREE_RESET_BIT      5
`define PSR_DMA_RESET_BIT              4
`define PSR_USB_RESET_BIT              3
`define PSR_ANALOG_CONVERTER_RESET_BIT 2
`define PSR_TIMER_GROUP_RESET_BIT      1
`define PSR_I2C_RESET_BIT              0
`define PSR_CTRL_MASK                  8'hbf

// ****************************************************************
// Reset values, counts and bus answers
// ****************************************************************
`define PSR_CTRL_RESET                 8'h00
`define PSR_COUNT_RESET                16'h0008
`define PSR_COUNT_MIN                  16'h0008
`define PSR_RESP_OKAY                  2'b00
`define PSR_RESP_SLVERR                2'b10

`endif

// File: shared/psr_pkg.sv
// Purpose: Types shared by the peripheral soft reset controller and its bus slave.
// Assumes: psr_map.svh supplies the widths.
// Notes:   Design module state is carried in the packed structs below, apart from the check registers hold_len and want_len in psr_ctrl.
`default_nettype none
`include "psr_map.svh"

package psr_pkg;

  // ****************************************************************
  // Countdown phase
  // ****************************************************************
  typedef enum logic [1:0] {
    PSR_IDLE = 2'b01,
    PSR_HOLD = 2'b10
  } psr_phase_type;

  // ****************************************************************
  // Register write strobe from the bus slave
  // ****************************************************************
  typedef struct packed {
    logic                   en;
    logic [`PSR_ADDR_W-1:0] addr;
    logic [31:0]            data;
    logic [3:0]             strb;
  } psr_wr_type;

  // ****************************************************************
  // Module states
  // ****************************************************************
  typedef struct packed {
    psr_phase_type phase;
    logic [15:0]   count;
    logic [7:0]    held;
    logic [15:0]   remaining;
  } psr_ctrl_state_type;

  typedef struct packed {
    logic                   aw_full;
    logic [`PSR_ADDR_W-1:0] aw_addr;
    logic                   w_full;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } psr_axi_state_type;

endpackage

`default_nettype wire

// File: verilog/psr_axil_slave.sv
// Purpose: AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes: One write and one read at most under way; 32-bit data.
// Notes:   Write answers one edge after both address and data are held; reads answer at the taking edge.
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"

module psr_axil_slave
  import psr_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PSR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PSR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output psr_wr_type                  wr,
  input  wire logic                   wr_ok,
  output logic                        rd_take,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ok
);

  psr_axi_state_type r_reg;
  psr_axi_state_type r_next;

  // Ready is offered while each holding slot is empty.
  assign s_axi_awready = !r_reg.aw_full;
  assign s_axi_wready  = !r_reg.w_full;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign rd_take       = s_axi_arvalid && !r_reg.rvalid;

  // A write strobe fires once both halves are held and no answer is pending.
  assign wr.en   = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
  assign wr.addr = r_reg.aw_addr;
  assign wr.data = r_reg.w_data;
  assign wr.strb = r_reg.w_strb;

  // Next state of the channel slots.
  always_comb begin
    r_next = r_reg;
    if (s_axi_awvalid && !r_reg.aw_full) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_full) begin
      r_next.w_full = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (wr.en) begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = wr_ok ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
    end else if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (rd_take) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = rd_data;
      r_next.rresp  = rd_ok ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

`default_nettype wire

// File: tb/psr_periph_model.sv
// Purpose: Stand-in for the reset inputs of the seven peripheral groups.
// Assumes: Each line is active low and sampled on the rising edge of aclk.
// Notes:   Records how many reset pulses each line saw and how long the last one was.
`timescale 1ns/1ps
`default_nettype none

module psr_periph_model (
  input  wire logic       aclk,
  input  wire logic [6:0] rst_n,
  output var  int         pulses   [7],
  output var  int         last_len [7]
);
  int run [7];

  // Clears the tallies at time zero.
  initial begin
    for (int i = 0; i < 7; i++) begin
      run[i]      = 0;
      pulses[i]   = 0;
      last_len[i] = 0;
    end
  end

  // Counts the cycles a line is held low and records the length when it is let go.
  always @(posedge aclk) begin
    for (int i = 0; i < 7; i++) begin
      // Only a firm low counts, so the unknown level before the first reset edge is no pulse.
      if (rst_n[i] === 1'b0) begin
        run[i] <= run[i] + 1;
      end else if (run[i] != 0) begin
        last_len[i] <= run[i];
        pulses[i]   <= pulses[i] + 1;
        run[i]      <= 0;
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/tb_peripheral_soft_reset_ctrl.sv
// Purpose: Self-checking bench for the peripheral soft reset controller.
// Assumes: AXI4-Lite master driven by non-blocking assignment just after rising edges.
// Notes:   Group line index i carries control bit bit_of[i].
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"

module tb_peripheral_soft_reset_ctrl;
  import psr_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_busy;
  logic        audio_uart_spi_rst_n, card_audio_rst_n, dma_rst_n, usb_rst_n, analog_rst_n, timer_rst_n, i2c_rst_n;
  logic [6:0]  lines;
  int          error_cnt, n_checks;
  int          pulses [7], last_len [7], exp_p [7];
  int          bit_of [7] = '{0, 1, 2, 3, 4, 5, 7};

  // Gathers the group lines in control bit order.
  assign lines = {audio_uart_spi_rst_n, card_audio_rst_n, dma_rst_n, usb_rst_n, analog_rst_n, timer_rst_n, i2c_rst_n};

  psr_ctrl psr_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .audio_uart_spi_rst_n, .card_audio_rst_n, .dma_rst_n, .usb_rst_n, .analog_rst_n, .timer_rst_n,
    .i2c_rst_n, .reset_busy);

  psr_periph_model psr_periph_model_inst (.aclk(aclk), .rst_n(lines), .pulses(pulses), .last_len(last_len));

  // Makes the 200 MHz clock.
  always #2.5 aclk = ~aclk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_go, w_go;
    int n;
    aw_go = 1;
    w_go = 1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw_go || w_go) && n < 100) begin
      @(posedge aclk);
      n++;
      if (aw_go && s_axi_awready === 1'b1) begin
        aw_go = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_go && s_axi_wready === 1'b1) begin
        w_go = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check("write answered", 32'h1, 32'(n < 200));
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    // Lets an edge pass so rready is never lowered and raised again in one time step.
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("read answered", 32'h1, 32'(n < 200));
  endtask

  // Polls the control register until every group has left reset.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_read(`PSR_CTRL_ADDR, rd, rsp);
      n++;
    end while (rd !== 32'h0000_0000 && n < 50);
    check("control after countdown", 32'h0000_0000, rd);
    check("busy after countdown", 32'h0, 32'(reset_busy));
  endtask

  task automatic check_pulses();
    for (int j = 0; j < 7; j++) begin
      check("pulse tally", 32'(exp_p[j]), 32'(pulses[j]));
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals();
    axi_read(`PSR_COUNT_ADDR, rd, rsp);
    check("count after reset", 32'h0000_0008, rd);
    axi_read(`PSR_CTRL_ADDR, rd, rsp);
    check("control after reset", 32'h0000_0000, rd);
    check("lines after reset", 32'h0000_007f, 32'(lines));
    $display("Test reset values done");
  endtask

  task automatic t_each_group();
    for (int i = 0; i < 7; i++) begin
      axi_write(`PSR_COUNT_ADDR, 32'h0000_0008 + 32'(i), rsp);
      axi_write(`PSR_CTRL_ADDR, 32'h1 << bit_of[i], rsp);
      check("busy while held", 32'h1, 32'(reset_busy));
      axi_read(`PSR_CTRL_ADDR, rd, rsp);
      check("control while held", 32'h1 << bit_of[i], rd);
      wait_idle();
      exp_p[i]++;
      check("held length", 32'h0000_0008 + 32'(i), 32'(last_len[i]));
      check_pulses();
    end
    $display("Test each group done");
  endtask

  task automatic t_zero_write();
    axi_write(`PSR_COUNT_ADDR, 32'h0000_0020, rsp);
    axi_write(`PSR_CTRL_ADDR, 32'h0000_0090, rsp);
    axi_write(`PSR_CTRL_ADDR, 32'h0000_0000, rsp);
    axi_read(`PSR_CTRL_ADDR, rd, rsp);
    check("control two groups", 32'h0000_0090, rd);
    wait_idle();
    exp_p[6]++;
    exp_p[4]++;
    check("group four length", 32'h0000_0020, 32'(last_len[6]));
    check("dma length", 32'h0000_0020, 32'(last_len[4]));
    check_pulses();
    axi_read(`PSR_COUNT_ADDR, rd, rsp);
    check("count readback", 32'h0000_0020, rd);
    $display("Test zero write done");
  endtask

  // A second write of ones lands three cycles into the first hold and restarts the full count.
  task automatic t_retrigger();
    axi_write(`PSR_COUNT_ADDR, 32'h0000_0010, rsp);
    axi_write(`PSR_CTRL_ADDR, 32'h0000_0001, rsp);
    axi_write(`PSR_CTRL_ADDR, 32'h0000_0008, rsp);
    axi_read(`PSR_CTRL_ADDR, rd, rsp);
    check("control after retrigger", 32'h0000_0009, rd);
    wait_idle();
    exp_p[0]++;
    exp_p[3]++;
    check("usb length", 32'h0000_0010, 32'(last_len[3]));
    check("i2c length", 32'h0000_0013, 32'(last_len[0]));
    check_pulses();
    $display("Test retrigger done");
  endtask

  task automatic t_unmapped();
    axi_write(16'h7018, 32'h0000_0001, rsp);
    check("unmapped write resp", 32'(`PSR_RESP_SLVERR), 32'(rsp));
    axi_read(16'h7018, rd, rsp);
    check("unmapped read resp", 32'(`PSR_RESP_SLVERR), 32'(rsp));
    check("unmapped read data", 32'h0000_0000, rd);
    check("lines untouched", 32'h0000_007f, 32'(lines));
    $display("Test unmapped done");
  endtask

  task automatic t_mid_reset();
    axi_write(`PSR_COUNT_ADDR, 32'h0000_0040, rsp);
    axi_write(`PSR_CTRL_ADDR, 32'h0000_0002, rsp);
    check("timer held", 32'h0, 32'(timer_rst_n));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    check("lines in chip reset", 32'h0000_007f, 32'(lines));
    check("busy in chip reset", 32'h0, 32'(reset_busy));
    aresetn <= 1'b1;
    @(posedge aclk);
    exp_p[1]++;
    axi_read(`PSR_COUNT_ADDR, rd, rsp);
    check("count after mid reset", 32'h0000_0008, rd);
    axi_read(`PSR_CTRL_ADDR, rd, rsp);
    check("control after mid reset", 32'h0000_0000, rd);
    check_pulses();
    $display("Test mid-run reset done");
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  // Holds reset for eight cycles, then runs every scenario.
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    error_cnt = 0;
    n_checks = 0;
    exp_p = '{default: 0};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_each_group();
    t_zero_write();
    t_retrigger();
    t_unmapped();
    t_mid_reset();
    close_out();
  end

  // Cuts a hang short well after the expected run of a few hundred cycles.
  initial begin
    #100000;
    error_cnt++;
    $display("Watchdog expired");
    close_out();
  end
endmodule

`default_nettype wire
